/* src/afp_pkg.sv */
// Constants and types shared by the amplifier fault protection sequencer.
package afp_pkg;

  // Clock and timing.
  localparam int unsigned CLK_HZ           = 10_000_000;
  localparam int unsigned CHECK_MS_PER_UF  = 15;
  localparam int unsigned FILTER_NF        = 1000;
  // Cycles for the whole check; a longest time, so it rounds down.
  localparam int unsigned CHECK_LIMIT_CYC  = CHECK_MS_PER_UF * (CLK_HZ / 1000) * FILTER_NF / 1000;
  localparam int unsigned RESET_HOLD_MS    = 4;
  // A least time, so it rounds up.
  localparam int unsigned RESET_HOLD_CYC   = (RESET_HOLD_MS * CLK_HZ + 999) / 1000;
  localparam int unsigned CNT_W            = 20;

  // Register bus layout.
  localparam int unsigned ADDR_W           = 4;
  localparam int unsigned DATA_W           = 8;
  localparam logic [3:0]  REG_CONFIG       = 4'h0;
  localparam logic [3:0]  REG_STATUS       = 4'h1;
  localparam logic [3:0]  REG_FLAGS        = 4'h2;

  // Configuration fields and reset value.
  localparam int unsigned CFG_MODE_LSB     = 0;
  localparam int unsigned CFG_QUAD_BIT     = 2;
  localparam logic [7:0]  CFG_RESET        = 8'h04;
  localparam logic [1:0]  MODE_BRIDGED     = 2'h0;
  localparam logic [1:0]  MODE_PARALLEL    = 2'h1;
  localparam logic [1:0]  MODE_SINGLE      = 2'h2;

  // Flags register bits; the early-reset flag clears by writing one.
  localparam int unsigned FLG_THERMAL      = 0;
  localparam int unsigned FLG_OVERLOAD     = 1;
  localparam int unsigned FLG_UNDERVOLT    = 2;
  localparam int unsigned FLG_SHORT        = 3;
  localparam int unsigned FLG_EARLY_RST    = 4;

  // Asynchronous input vector positions.
  localparam int unsigned IN_T100          = 0;
  localparam int unsigned IN_T125          = 1;
  localparam int unsigned IN_T155          = 2;
  localparam int unsigned IN_LOGIC_UV      = 3;
  localparam int unsigned IN_GATE_UV       = 4;
  localparam int unsigned IN_SHORT_GND     = 8;
  localparam int unsigned IN_SHORT_SUP     = 9;
  localparam int unsigned IN_OVERCUR       = 10;
  localparam int unsigned IN_OVERLOAD      = 11;
  localparam int unsigned IN_CLIP          = 12;
  localparam int unsigned IN_TRIM_TIED     = 13;
  localparam int unsigned IN_RESET         = 14;
  localparam int unsigned NUM_IN           = 15;
  // Logic supply reads as low until the synchronisers have seen it, so no check starts early.
  localparam logic [14:0] SYNC_RESET       = 15'h0008;

  // Sequencer states, one-hot.
  typedef enum logic [3:0] {
    ST_POWERUP   = 4'h1,
    ST_CHECK_GND = 4'h2,
    ST_CHECK_SUP = 4'h4,
    ST_RUN       = 4'h8
  } afp_state_t;

endpackage : afp_pkg

/* src/afp_sequencer.sv */
// Start-up, pin short check and fault protection sequencer for a four half-bridge stage.
`timescale 1ns/100ps
module afp_sequencer #(
  parameter int unsigned CHECK_LIMIT_CYC = afp_pkg::CHECK_LIMIT_CYC,
  parameter int unsigned RESET_HOLD_CYC  = afp_pkg::RESET_HOLD_CYC
) (
  input  wire logic                       clk_sys,
  input  wire logic                       rst_n,
  input  wire logic [afp_pkg::ADDR_W-1:0] regAddr,
  input  wire logic [afp_pkg::DATA_W-1:0] regWdata,
  input  wire logic                       regWrite,
  input  wire logic                       regRead,
  output logic      [afp_pkg::DATA_W-1:0] regRdata,
  input  wire logic                       resetPinN,
  input  wire logic                       tempOver100,
  input  wire logic                       tempOver125,
  input  wire logic                       tempOver155,
  input  wire logic                       logicSupplyLow,
  input  wire logic [3:0]                 gateSupplyLow,
  input  wire logic                       shortToGnd,
  input  wire logic                       shortToSupply,
  input  wire logic                       overcurrentGuard,
  input  wire logic                       overloadGuard,
  input  wire logic                       clipNear,
  input  wire logic                       freqTrimTied,
  output logic [3:0]                      bridgeEnable,
  output logic [3:0]                      pulldownEnable,
  output logic                            faultShutdownNOut,
  output logic                            faultShutdownNOeN,
  output logic                            tempWarnNOut,
  output logic                            tempWarnNOeN,
  output logic                            tempWarnLowNOut,
  output logic                            tempWarnLowNOeN,
  output logic                            tempWarnHighNOut,
  output logic                            tempWarnHighNOeN,
  output logic                            ready,
  output logic                            clip,
  output logic                            oscInternalEnable,
  output logic [1:0]                      clockSyncPinsOeN
);

  // Whole module state in one record.
  typedef struct packed {
    afp_pkg::afp_state_t              state;
    logic [afp_pkg::NUM_IN-1:0]       syncA;
    logic [afp_pkg::NUM_IN-1:0]       syncB;
    logic [7:0]                       cfgReg;
    logic                             thermalLatch;
    logic                             overloadLatch;
    logic                             shortSeen;
    logic                             earlyReset;
    logic                             resetPrev;
    logic                             holdActive;
    logic [afp_pkg::CNT_W-1:0]        phaseCount;
    logic [afp_pkg::CNT_W-1:0]        holdCount;
    logic [3:0]                       bridgeEn;
    logic [3:0]                       pulldownEn;
    logic                             sdDrive;
    logic                             warnDrive;
    logic                             warnLowDrive;
    logic                             warnHighDrive;
    logic                             readyFlag;
    logic                             clipFlag;
    logic                             slaveMode;
    logic [afp_pkg::DATA_W-1:0]       rdata;
  } afp_regs_t;

  localparam logic [afp_pkg::CNT_W-1:0] PHASE_CYC = afp_pkg::CNT_W'(CHECK_LIMIT_CYC / 2);
  localparam logic [afp_pkg::CNT_W-1:0] HOLD_CYC  = afp_pkg::CNT_W'(RESET_HOLD_CYC);

  afp_regs_t r;
  afp_regs_t next_r;
  logic [afp_pkg::NUM_IN-1:0] asyncIn;

  // Decodes the output configuration field.
  function automatic logic isSingleEnded(input logic [7:0] cfg);
    isSingleEnded = (cfg[afp_pkg::CFG_MODE_LSB +: 2] == afp_pkg::MODE_SINGLE);
  endfunction : isSingleEnded

  // Saturating up-counter used by both timers.
  function automatic logic [afp_pkg::CNT_W-1:0] countUp(input logic [afp_pkg::CNT_W-1:0] v);
    countUp = (&v) ? v : v + afp_pkg::CNT_W'(1);
  endfunction : countUp

  assign asyncIn = {resetPinN, freqTrimTied, clipNear, overloadGuard, overcurrentGuard,
                    shortToSupply, shortToGnd, gateSupplyLow, logicSupplyLow,
                    tempOver155, tempOver125, tempOver100};

  // Synchronised views; only the second stage is ever read.
  logic inReset;
  logic uvAny;
  logic inCheck;
  logic resetRise;
  assign inReset   = !r.syncB[afp_pkg::IN_RESET];
  assign uvAny     = |r.syncB[afp_pkg::IN_GATE_UV +: 4] | r.syncB[afp_pkg::IN_LOGIC_UV];
  assign inCheck   = (r.state == afp_pkg::ST_CHECK_GND) || (r.state == afp_pkg::ST_CHECK_SUP);
  assign resetRise = r.syncB[afp_pkg::IN_RESET] && !r.resetPrev;

  // Next-state logic for the whole block.
  always_comb begin
    logic faultNow;
    logic quad;
    faultNow = 1'b0;
    quad     = 1'b0;
    next_r   = r;
    next_r.syncA = asyncIn;
    next_r.syncB = r.syncA;
    next_r.resetPrev = r.syncB[afp_pkg::IN_RESET];
    quad = r.cfgReg[afp_pkg::CFG_QUAD_BIT];

    // Start-up sequencer; it can only reach the check from power-up.
    case (r.state)
      afp_pkg::ST_POWERUP: begin
        next_r.phaseCount = '0;
        if (!uvAny) begin
          if (isSingleEnded(r.cfgReg)) begin
            next_r.state = afp_pkg::ST_RUN;
          end else begin
            next_r.state = afp_pkg::ST_CHECK_GND;
          end
        end
      end
      afp_pkg::ST_CHECK_GND: begin
        // A short restarts the phase timer, so the stage waits in Hi-Z until it is gone.
        if (r.syncB[afp_pkg::IN_SHORT_GND]) begin
          next_r.phaseCount = '0;
          next_r.shortSeen  = 1'b1;
        end else if (r.phaseCount >= PHASE_CYC - afp_pkg::CNT_W'(1)) begin
          next_r.phaseCount = '0;
          next_r.state      = afp_pkg::ST_CHECK_SUP;
        end else begin
          next_r.phaseCount = countUp(r.phaseCount);
        end
      end
      afp_pkg::ST_CHECK_SUP: begin
        if (r.syncB[afp_pkg::IN_SHORT_SUP]) begin
          next_r.phaseCount = '0;
          next_r.shortSeen  = 1'b1;
        end else if (r.phaseCount >= PHASE_CYC - afp_pkg::CNT_W'(1)) begin
          next_r.phaseCount = '0;
          next_r.state      = afp_pkg::ST_RUN;
        end else begin
          next_r.phaseCount = countUp(r.phaseCount);
        end
      end
      afp_pkg::ST_RUN: begin
        next_r.state = afp_pkg::ST_RUN;
      end
      default: begin
        next_r.state = afp_pkg::ST_POWERUP;
      end
    endcase
    if (next_r.state == afp_pkg::ST_RUN) begin
      next_r.shortSeen = 1'b0;
    end

    // Thermal latch: only reset low clears it, and a new trip wins.
    if (r.state == afp_pkg::ST_RUN && r.syncB[afp_pkg::IN_T155]) begin
      next_r.thermalLatch = 1'b1;
    end else if (inReset && !inCheck) begin
      next_r.thermalLatch = 1'b0;
    end

    // Overload latch: cleared on the reset rising edge, set wins.
    if (r.state == afp_pkg::ST_RUN && r.syncB[afp_pkg::IN_OVERLOAD]) begin
      next_r.overloadLatch = 1'b1;
    end else if (resetRise && !inCheck) begin
      next_r.overloadLatch = 1'b0;
    end

    // Times the controller's reset release after the shutdown output fell.
    if (r.sdDrive && !next_r.sdDrive) begin
      next_r.holdActive = 1'b0;
    end
    faultNow = r.thermalLatch || r.overloadLatch || uvAny;

    // Output drives; check holds shutdown low and hides the reset pin.
    if (inCheck) begin
      next_r.sdDrive = 1'b1;
    end else if (inReset) begin
      next_r.sdDrive = 1'b0;
    end else begin
      next_r.sdDrive = faultNow;
    end
    if (!r.sdDrive && next_r.sdDrive) begin
      next_r.holdActive = 1'b1;
      next_r.holdCount  = '0;
    end else if (r.holdActive) begin
      next_r.holdCount = countUp(r.holdCount);
    end
    if (r.holdActive && resetRise && r.holdCount < HOLD_CYC) begin
      next_r.earlyReset = 1'b1;
    end

    // Switching only in run, out of reset and with no fault present.
    if (r.state == afp_pkg::ST_RUN && !inReset && !faultNow) begin
      next_r.bridgeEn = 4'hF;
    end else begin
      next_r.bridgeEn = 4'h0;
    end
    if (!inCheck && inReset && !isSingleEnded(r.cfgReg)) begin
      next_r.pulldownEn = 4'hF;
    end else begin
      next_r.pulldownEn = 4'h0;
    end

    // Temperature warnings by package variant.
    next_r.warnHighDrive = quad && r.syncB[afp_pkg::IN_T125];
    next_r.warnLowDrive  = quad && r.syncB[afp_pkg::IN_T100];
    next_r.warnDrive     = !quad && r.syncB[afp_pkg::IN_T125];

    next_r.readyFlag = r.state == afp_pkg::ST_RUN && !r.syncB[afp_pkg::IN_OVERCUR];
    next_r.clipFlag  = r.syncB[afp_pkg::IN_CLIP];
    next_r.slaveMode = r.syncB[afp_pkg::IN_TRIM_TIED];

    // Register port: writes to configuration, one-to-clear on flags.
    if (regWrite && regAddr == afp_pkg::REG_CONFIG) begin
      next_r.cfgReg = regWdata;
    end
    if (regWrite && regAddr == afp_pkg::REG_FLAGS && regWdata[afp_pkg::FLG_EARLY_RST]
        && !(r.holdActive && resetRise && r.holdCount < HOLD_CYC)) begin
      next_r.earlyReset = 1'b0;
    end
    next_r.rdata = '0;
    if (regRead) begin
      case (regAddr)
        afp_pkg::REG_CONFIG: begin
          next_r.rdata = r.cfgReg;
        end
        afp_pkg::REG_STATUS: begin
          next_r.rdata = {r.slaveMode, r.readyFlag, r.sdDrive, 1'b0, r.state};
        end
        afp_pkg::REG_FLAGS: begin
          next_r.rdata = {3'h0, r.earlyReset, r.shortSeen, uvAny, r.overloadLatch, r.thermalLatch};
        end
        default: begin
          next_r.rdata = '0;
        end
      endcase
    end
  end

  // Power-on clear puts the sequencer back at start and empties the latches.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      r <= '{state: afp_pkg::ST_POWERUP, syncA: afp_pkg::SYNC_RESET, syncB: afp_pkg::SYNC_RESET,
             cfgReg: afp_pkg::CFG_RESET, phaseCount: '0, holdCount: '0, bridgeEn: 4'h0,
             pulldownEn: 4'h0, rdata: '0, default: 1'b0};
    end else begin
      r <= next_r;
    end
  end

  // Open-drain pins pull low only; enable low means driving.
  assign faultShutdownNOut  = 1'b0;
  assign faultShutdownNOeN  = !r.sdDrive;
  assign tempWarnNOut       = 1'b0;
  assign tempWarnNOeN       = !r.warnDrive;
  assign tempWarnLowNOut    = 1'b0;
  assign tempWarnLowNOeN    = !r.warnLowDrive;
  assign tempWarnHighNOut   = 1'b0;
  assign tempWarnHighNOeN   = !r.warnHighDrive;
  assign bridgeEnable       = r.bridgeEn;
  assign pulldownEnable     = r.pulldownEn;
  assign ready              = r.readyFlag;
  assign clip               = r.clipFlag;
  assign oscInternalEnable  = !r.slaveMode;
  assign clockSyncPinsOeN   = {2{r.slaveMode}};
  assign regRdata           = r.rdata;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  sequence s_gndPhaseEnds;
    r.state == afp_pkg::ST_CHECK_GND ##1 r.state != afp_pkg::ST_CHECK_GND;
  endsequence

  sequence s_tripSeen;
    r.state == afp_pkg::ST_RUN && r.syncB[afp_pkg::IN_T155];
  endsequence

  a_check_sd_low: assert property (inCheck |-> ##1 !faultShutdownNOeN)
    else $error("shutdown released during pin short check");
  a_reset_sd_high: assert property (!inCheck && inReset && !$past(inCheck) |-> ##1 faultShutdownNOeN)
    else $error("shutdown not forced high in reset");
  a_phase_order: assert property (s_gndPhaseEnds |-> r.state == afp_pkg::ST_CHECK_SUP)
    else $error("ground phase not followed by supply phase");
  a_run_is_final: assert property (r.state == afp_pkg::ST_RUN |=> r.state == afp_pkg::ST_RUN)
    else $error("sequencer left run state");
  a_single_skip: assert property (r.state == afp_pkg::ST_POWERUP && !uvAny && isSingleEnded(r.cfgReg)
                                  |=> r.state == afp_pkg::ST_RUN)
    else $error("single-ended start did not skip check");
  a_thermal_trip: assert property (s_tripSeen |=> r.thermalLatch ##1 bridgeEnable == 4'h0)
    else $error("thermal trip not latched into Hi-Z");
  a_thermal_holds: assert property (r.thermalLatch && !inReset |=> r.thermalLatch)
    else $error("thermal latch cleared without reset");
  a_uv_hiz: assert property (uvAny && !inCheck && !inReset |=> bridgeEnable == 4'h0 && !faultShutdownNOeN)
    else $error("undervoltage did not stop the stage");
  a_uv_recover: assert property (r.state == afp_pkg::ST_RUN && !uvAny && !r.thermalLatch && !r.overloadLatch
                                 && !inReset |=> bridgeEnable == 4'hF)
    else $error("no recovery after supplies returned");
  a_sync_delay: assert property ($rose(r.thermalLatch) |-> $past(tempOver155, 3))
    else $error("thermal input used before synchronisation");
  a_phase_bound: assert property (inCheck |-> r.phaseCount < PHASE_CYC)
    else $error("check phase exceeded its time");
  a_pulldown_on: assert property (!inCheck && inReset && !isSingleEnded(r.cfgReg) |=> pulldownEnable == 4'hF)
    else $error("no weak pulldown in reset");
  a_ready_drop: assert property (r.syncB[afp_pkg::IN_OVERCUR] |=> !ready)
    else $error("ready stayed high on overcurrent");
  a_slave_osc: assert property (r.syncB[afp_pkg::IN_TRIM_TIED] |=> !oscInternalEnable ##0 clockSyncPinsOeN == 2'h3)
    else $error("oscillator not in slave mode");

endmodule : afp_sequencer

/* verification/afp_ctrl_model.sv */
// Behavioural system controller that drives the reset pin of the power stage.
`timescale 1ns/100ps
module afp_ctrl_model #(
  parameter int unsigned HOLD_CYC = 10
) (
  input  wire logic clk_sys,
  input  wire logic rst_n,
  input  wire logic faultPinN,
  input  wire logic resetReq,
  output logic      resetPinN
);
  int unsigned sinceFall;
  int unsigned lowCnt;
  logic        lastPin;

  // Cycles since the shutdown line last fell, saturated so an old fall never wraps round.
  always_ff @(posedge clk_sys) begin
    lastPin <= faultPinN;
    if (!rst_n) begin
      sinceFall <= HOLD_CYC;
    end else if (lastPin && !faultPinN) begin
      sinceFall <= 0;
    end else if (sinceFall < HOLD_CYC) begin
      sinceFall <= sinceFall + 1;
    end
  end

  // Reset is pulled low on request and let go only once the hold time has run out.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      resetPinN <= 1'b1;
      lowCnt    <= 0;
    end else if (resetReq) begin
      resetPinN <= 1'b0;
      lowCnt    <= 0;
    end else if (!resetPinN) begin
      lowCnt <= lowCnt + 1;
      if (lowCnt >= 3 && sinceFall >= HOLD_CYC) resetPinN <= 1'b1;
    end
  end
endmodule : afp_ctrl_model

/* verification/tb.sv */
// Self-checking bench for the amplifier fault protection sequencer.
`timescale 1ns/100ps
module tb;
  localparam int unsigned CHK = 20;
  localparam int unsigned HOLD = 10;
  logic       clk_sys = 1'b0;
  logic       rst_n = 1'b0;
  logic [3:0] regAddr = 4'h0;
  logic [7:0] regWdata = 8'h00;
  logic [7:0] regRdata;
  logic       regWrite = 1'b0, regRead = 1'b0, resetReq = 1'b0, resetPinN;
  logic       tempOver100 = 1'b0, tempOver125 = 1'b0, tempOver155 = 1'b0;
  logic       logicSupplyLow = 1'b1, shortToGnd = 1'b0, shortToSupply = 1'b0;
  logic [3:0] gateSupplyLow = 4'h0;
  logic       overcurrentGuard = 1'b0, overloadGuard = 1'b0, clipNear = 1'b0, freqTrimTied = 1'b0;
  logic [3:0] bridgeEnable, pulldownEnable;
  logic       fsOut, fsOeN, twOeN, twlOeN, twhOeN, ready, clip, oscInternalEnable;
  logic [1:0] clockSyncPinsOeN;
  wire        faultPinN = fsOeN ? 1'b1 : fsOut;
  int         fail_count = 0;
  int         samples_checked = 0;
  int         cycles = 0;

  afp_sequencer #(.CHECK_LIMIT_CYC(CHK), .RESET_HOLD_CYC(HOLD)) dut_u (
    .clk_sys(clk_sys), .rst_n(rst_n), .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite),
    .regRead(regRead), .regRdata(regRdata), .resetPinN(resetPinN), .tempOver100(tempOver100),
    .tempOver125(tempOver125), .tempOver155(tempOver155), .logicSupplyLow(logicSupplyLow),
    .gateSupplyLow(gateSupplyLow), .shortToGnd(shortToGnd), .shortToSupply(shortToSupply),
    .overcurrentGuard(overcurrentGuard), .overloadGuard(overloadGuard), .clipNear(clipNear),
    .freqTrimTied(freqTrimTied), .bridgeEnable(bridgeEnable), .pulldownEnable(pulldownEnable),
    .faultShutdownNOut(fsOut), .faultShutdownNOeN(fsOeN), .tempWarnNOut(), .tempWarnNOeN(twOeN),
    .tempWarnLowNOut(), .tempWarnLowNOeN(twlOeN), .tempWarnHighNOut(), .tempWarnHighNOeN(twhOeN),
    .ready(ready), .clip(clip), .oscInternalEnable(oscInternalEnable), .clockSyncPinsOeN(clockSyncPinsOeN));

  afp_ctrl_model #(.HOLD_CYC(HOLD)) ctrl_u (
    .clk_sys(clk_sys), .rst_n(rst_n), .faultPinN(faultPinN), .resetReq(resetReq), .resetPinN(resetPinN));

  // Clock of 100 ns; a hang is cut off well after the longest expected run.
  always #50 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fail_count++;
      $display("ERROR %0t timeout", $time);
      complete_run();
    end
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string msg);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %0t %s got %h expected %h", $time, msg, got, exp);
    end
  endtask : chk

  // Checks are made at the falling edge, where every registered output has settled.
  task automatic wt(input int n);
    repeat (n) @(negedge clk_sys);
  endtask : wt

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    regWrite <= 1'b1;
    regAddr  <= a;
    regWdata <= d;
    @(posedge clk_sys);
    regWrite <= 1'b0;
  endtask : wr

  // Read data stand only in the cycle after the strobe, so they are taken there.
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    regRead <= 1'b1;
    regAddr <= a;
    @(posedge clk_sys);
    regRead <= 1'b0;
    @(negedge clk_sys);
    d = regRdata;
  endtask : rd

  task automatic wait_state(input logic [3:0] st, output int n);
    logic [7:0] d;
    n = 0;
    do begin
      rd(afp_pkg::REG_STATUS, d);
      n += 3;
    end while (d[3:0] !== st && n < 90);
    chk(8'(d[3:0]), 8'(st), "sequencer state");
  endtask : wait_state

  // Pulse a reset request and wait until the controller lets the pin go again.
  task automatic pin_reset();
    int n;
    @(posedge clk_sys);
    resetReq <= 1'b1;
    @(posedge clk_sys);
    resetReq <= 1'b0;
    wt(4);
    chk(8'(bridgeEnable), 8'h00, "reset low bridges");
    chk(8'(fsOeN), 8'h01, "reset low shutdown");
    chk(8'(pulldownEnable), 8'h0F, "reset low weak pulldown");
    for (n = 0; n < 60 && resetPinN !== 1'b1; n++) wt(1);
  endtask : pin_reset

  task automatic t_startup();
    logic [7:0] d;
    int         n1;
    int         n2;
    wt(6);
    chk(8'(bridgeEnable), 8'h00, "undervoltage bridges");
    chk(8'(fsOeN), 8'h00, "undervoltage shutdown");
    rd(afp_pkg::REG_CONFIG, d);
    chk(d, afp_pkg::CFG_RESET, "config reset value");
    wr(4'hF, 8'hFF);
    rd(4'hF, d);
    chk(d, 8'h00, "unmapped read");
    shortToGnd     <= 1'b1;
    logicSupplyLow <= 1'b0;
    resetReq       <= 1'b1;
    wt(40);
    resetReq <= 1'b0;
    chk(8'(fsOeN), 8'h00, "shutdown in check");
    chk(8'(bridgeEnable), 8'h00, "short holds Hi-Z");
    wait_state(4'h2, n1);
    shortToGnd <= 1'b0;
    do rd(afp_pkg::REG_STATUS, d); while (d[3:0] === 4'h2);
    chk(8'(d[3:0]), 8'h04, "supply phase follows ground phase");
    wait_state(4'h8, n2);
    chk(8'(n2 <= CHK + 6), 8'h01, "check duration");
    wt(4);
    chk(8'(fsOeN), 8'h01, "check passed releases");
    chk(8'(bridgeEnable), 8'h0F, "switching after check");
    $display("test startup done");
  endtask : t_startup

  task automatic t_latch(input bit thermal);
    logic [7:0] d;
    if (thermal) begin
      tempOver100 <= 1'b1;
      wt(6);
      chk(8'({twlOeN, twhOeN}), 8'h01, "first warning only");
      tempOver125 <= 1'b1;
      wt(6);
      chk(8'({twlOeN, twhOeN, twOeN}), 8'h01, "both warnings");
      tempOver155 <= 1'b1;
    end else overloadGuard <= 1'b1;
    wt(6);
    chk(8'({bridgeEnable, fsOeN}), 8'h00, "trip shuts down");
    rd(afp_pkg::REG_FLAGS, d);
    chk(8'(thermal ? d[0] : d[1]), 8'h01, "latch flag");
    {tempOver100, tempOver125, tempOver155, overloadGuard} <= 4'h0;
    wt(8);
    chk(8'({bridgeEnable, fsOeN}), 8'h00, "latch holds");
    pin_reset();
    wt(6);
    chk(8'(bridgeEnable), 8'h0F, "resumes after reset");
    rd(afp_pkg::REG_STATUS, d);
    chk(8'(d[3:0]), 8'h08, "no new check");
    $display("test latch %0d done", thermal);
  endtask : t_latch

  task automatic t_misc();
    gateSupplyLow <= 4'h4;
    wt(6);
    chk(8'({bridgeEnable, fsOeN}), 8'h00, "gate undervoltage");
    gateSupplyLow <= 4'h0;
    shortToSupply <= 1'b1;
    wt(6);
    chk(8'({bridgeEnable, fsOeN}), 8'h1F, "auto recovery");
    chk(8'(ready), 8'h01, "late short ignored");
    {shortToSupply, overcurrentGuard, clipNear, freqTrimTied} <= 4'h7;
    wt(6);
    chk(8'({ready, clip}), 8'h01, "overcurrent and clip");
    chk(8'({oscInternalEnable, clockSyncPinsOeN}), 8'h03, "slave mode");
    {overcurrentGuard, clipNear, freqTrimTied} <= 3'h0;
    wt(6);
    chk(8'({ready, oscInternalEnable, clockSyncPinsOeN}), 8'h0C, "master again");
    $display("test misc done");
  endtask : t_misc

  task automatic t_single();
    logic [7:0] d;
    int         n;
    overloadGuard <= 1'b1;
    wt(6);
    rst_n          <= 1'b0;
    overloadGuard  <= 1'b0;
    logicSupplyLow <= 1'b1;
    wt(8);
    rst_n <= 1'b1;
    wt(4);
    wr(afp_pkg::REG_CONFIG, 8'h02);
    rd(afp_pkg::REG_FLAGS, d);
    chk(8'(d[1]), 8'h00, "power-on clear overload");
    logicSupplyLow <= 1'b0;
    wait_state(4'h8, n);
    chk(8'(n <= 9), 8'h01, "check skipped");
    tempOver100 <= 1'b1;
    wt(6);
    chk(8'(twOeN), 8'h01, "no low warning");
    tempOver125 <= 1'b1;
    wt(6);
    chk(8'(twOeN), 8'h00, "single warning");
    {tempOver100, tempOver125} <= 2'h0;
    resetReq <= 1'b1;
    wt(6);
    resetReq <= 1'b0;
    chk(8'({bridgeEnable, pulldownEnable}), 8'h00, "single-ended stays Hi-Z");
    wt(20);
    $display("test single done");
  endtask : t_single

  task automatic complete_run();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : complete_run

  initial begin
    repeat (8) @(posedge clk_sys);
    rst_n <= 1'b1;
    t_startup();
    t_latch(1'b1);
    t_latch(1'b0);
    t_misc();
    t_single();
    complete_run();
  end
endmodule : tb
